// ### design/sfs_pkg.sv
// Shared constants, table contents and types of the parameter-table slave
package sfs_pkg;

    // Opcodes seen on the single data line
    localparam logic [7:0] OP_READ_TABLE = 8'h5A;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;

    // Frame layout in serial clock cycles
    localparam logic [4:0] OPCODE_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [4:0] DUMMY_LAST = 5'h07;

    // Software reset time and its cycle count at the core clock
    localparam int CLOCK_MHZ = 250;
    localparam int RESET_TIME_NS = 10000;
    localparam int RESET_CYCLES = (RESET_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [11:0] RESET_COUNT_LOAD = 12'(RESET_CYCLES - 1);

    // Table word offsets (byte addresses)
    localparam logic [7:0] OFS_ERASE_TYPES_THREE_FOUR = 8'h50;
    localparam logic [7:0] OFS_SUPPLY_VOLTAGE_LIMITS = 8'h60;
    localparam logic [7:0] OFS_RESET_SUSPEND_WRAP_FEATURES = 8'h64;
    localparam logic [7:0] OFS_BLOCK_LOCK_FEATURES = 8'h68;
    localparam logic [7:0] OFS_UNUSED_TAIL_WORD = 8'h6C;

    // Table word contents, lowest byte at the lowest address
    localparam logic [31:0] VAL_ERASE_TYPES_THREE_FOUR = 32'hFF00_D810;
    localparam logic [31:0] VAL_SUPPLY_VOLTAGE_LIMITS = 32'h2700_3600;
    localparam logic [31:0] VAL_RESET_SUSPEND_WRAP_FEATURES = 32'h6477_F99F;
    localparam logic [31:0] VAL_BLOCK_LOCK_FEATURES = 32'hFFFF_F800;
    localparam logic [31:0] VAL_UNUSED_TAIL_WORD = 32'hFFFF_FFFF;
    localparam logic [31:0] VAL_BLANK_WORD = 32'hFFFF_FFFF;
    localparam logic [7:0] VAL_BLANK_BYTE = 8'hFF;

    // Serial pins sampled together
    typedef struct packed {
        logic csN;
        logic sclk;
        logic mosi;
    } sfs_pins_t;

    localparam sfs_pins_t PINS_IDLE = 3'h6;

    // Frame decoder states
    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfs_state_t;

endpackage

// ### design/sfs_table_rom.sv
// Parameter-table byte store with registered read data
`timescale 1ns/10ps
module sfs_table_rom (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Read port
    input wire logic [7:0] addr,
    output logic [7:0] data
);

    logic [31:0] word;
    logic [7:0] next_data;

    // Word lookup; anything not listed reads blank
    always_comb begin
        word = sfs_pkg::VAL_BLANK_WORD;
        if (addr[7:2] == sfs_pkg::OFS_ERASE_TYPES_THREE_FOUR[7:2]) begin
            word = sfs_pkg::VAL_ERASE_TYPES_THREE_FOUR;
        end else if (addr[7:2] == sfs_pkg::OFS_SUPPLY_VOLTAGE_LIMITS[7:2]) begin
            word = sfs_pkg::VAL_SUPPLY_VOLTAGE_LIMITS;
        end else if (addr[7:2] ==
                     sfs_pkg::OFS_RESET_SUSPEND_WRAP_FEATURES[7:2]) begin
            word = sfs_pkg::VAL_RESET_SUSPEND_WRAP_FEATURES;
        end else if (addr[7:2] == sfs_pkg::OFS_BLOCK_LOCK_FEATURES[7:2]) begin
            word = sfs_pkg::VAL_BLOCK_LOCK_FEATURES;
        end else if (addr[7:2] == sfs_pkg::OFS_UNUSED_TAIL_WORD[7:2]) begin
            word = sfs_pkg::VAL_UNUSED_TAIL_WORD;
        end
        next_data = word[{addr[1:0], 3'h0} +: 8];
    end

    // Read register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data <= sfs_pkg::VAL_BLANK_BYTE;
        end else begin
            data <= next_data;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_erase_three:
    assert property (addr[7:1] == 7'h28 |=>
                     data == ($past(addr[0]) ? 8'hD8 : 8'h10))
        else $error("erase type 3 bytes wrong");
    a_erase_four:
    assert property (addr == 8'h52 |=> data == 8'h00 && $past(addr) == 8'h52)
        else $error("erase type 4 size wrong");
    a_erase_four_op:
    assert property (addr == 8'h53 |=> data == 8'hFF)
        else $error("erase type 4 opcode wrong");
    a_supply_bytes:
    assert property (addr[7:2] == 6'h18 |=> data ==
                     ($past(addr[0]) ? ($past(addr[1]) ? 8'h27 : 8'h36) : 8'h00))
        else $error("supply limit bytes wrong");
    a_wrap_bytes:
    assert property (addr[7:1] == 7'h33 |=>
                     data == ($past(addr[0]) ? 8'h64 : 8'h77))
        else $error("wrap fields wrong");
    a_blank_bytes:
    assert property (addr < 8'h50 || addr > 8'h6F |=> data == 8'hFF)
        else $error("unused byte not blank");

endmodule

// ### design/sfs_table_slave.sv
// Single-line serial slave that serves the parameter table and soft reset
`timescale 1ns/10ps
// Summary of operation
// - Works with master in mode 0 or mode 3, told by idle clock level.
// - Every input bit is taken on a rising serial clock edge.
// - Output bits change on falling edges, ready for next rising edge.
// - A clock cycle spans one falling edge to the next.
// - In mode 0 the first cycle starts at chip select falling.
// - Erase type 3 reports size code 10h and opcode D8h.
// - Erase type 4 reports size 00h and opcode FFh, unsupported.
// - Supply limits read 3600h max and 2700h min, low byte first.
// - Wrap length code 64h; wrap opcode field 77h, not supported.
// - Dummy cycles follow the address bits, or the mode clocks.
// - Table read accepted only in uniform widths; single line here.
// - Every unused table byte reads FFh.
// - Width triple names lines for opcode, address and data phases.
// - Reset-enable then reset back to back; 10us busy, commands refused.
module sfs_table_slave (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial link pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    // Status
    output logic resetBusy
);

    sfs_pkg::sfs_pins_t pinsMeta;
    sfs_pkg::sfs_pins_t pinsSync;
    sfs_pkg::sfs_pins_t pinsPrev;
    logic riseE;
    logic fallE;
    logic csRise;

    sfs_pkg::sfs_state_t state;
    sfs_pkg::sfs_state_t next_state;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [7:0] shiftIn;
    logic [7:0] next_shiftIn;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic [7:0] outShift;
    logic [7:0] next_outShift;
    logic [2:0] bitOut;
    logic [2:0] next_bitOut;
    logic [7:0] lastOp;
    logic [7:0] next_lastOp;
    logic opDone;
    logic next_opDone;
    logic armed;
    logic next_armed;
    logic [11:0] busyCnt;
    logic [11:0] next_busyCnt;
    logic next_resetBusy;
    logic next_miso;
    logic next_misoOe;
    logic [7:0] romData;
    logic [7:0] opWord;

    // Two-stage pin synchroniser, then one more stage for edge finding
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinsMeta <= sfs_pkg::PINS_IDLE;
            pinsSync <= sfs_pkg::PINS_IDLE;
            pinsPrev <= sfs_pkg::PINS_IDLE;
        end else begin
            pinsMeta <= {csN, sclk, mosi};
            pinsSync <= pinsMeta;
            pinsPrev <= pinsSync;
        end
    end

    // Edge events; only stages after the first are looked at
    assign riseE = pinsSync.sclk && !pinsPrev.sclk;
    assign fallE = !pinsSync.sclk && pinsPrev.sclk;
    assign csRise = pinsSync.csN && !pinsPrev.csN;
    assign opWord = {shiftIn[6:0], pinsSync.mosi};

    // Table store, read continuously at the current address
    sfs_table_rom u_rom (
        .clock(clock),
        .rst(rst),
        .addr(addr),
        .data(romData)
    );

    // Frame decoder, output shifter and soft-reset sequencing
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shiftIn = shiftIn;
        next_addr = addr;
        next_outShift = outShift;
        next_bitOut = bitOut;
        next_lastOp = lastOp;
        next_opDone = opDone;
        next_armed = armed;
        next_busyCnt = busyCnt;
        next_resetBusy = resetBusy;
        next_miso = miso;
        next_misoOe = misoOe;
        // Reset period countdown
        if (resetBusy) begin
            if (busyCnt == 12'h000) begin
                next_resetBusy = 1'b0;
            end else begin
                next_busyCnt = busyCnt - 12'h001;
            end
        end
        if (pinsSync.csN) begin
            // Deselected: next frame restarts at its opcode
            next_state = sfs_sets_cmd();
            next_cnt = 5'h00;
            next_bitOut = 3'h0;
            next_misoOe = 1'b0;
            next_opDone = 1'b0;
            if (csRise && opDone) begin
                // One-byte commands act at deselect
                if (lastOp == sfs_pkg::OP_RESET_ENABLE && !resetBusy) begin
                    next_armed = 1'b1;
                end else if (lastOp == sfs_pkg::OP_RESET && armed) begin
                    next_armed = 1'b0;
                    next_resetBusy = 1'b1;
                    next_busyCnt = sfs_pkg::RESET_COUNT_LOAD;
                end else begin
                    next_armed = 1'b0;
                end
            end
        end else begin
            if (riseE) begin
                case (state)
                    sfs_pkg::ST_CMD: begin
                        // Falls seen before the first rise do nothing
                        next_shiftIn = opWord;
                        next_cnt = cnt + 5'h01;
                        if (cnt == sfs_pkg::OPCODE_LAST) begin
                            next_opDone = 1'b1;
                            next_lastOp = opWord;
                            next_cnt = 5'h00;
                            // Single line for all three phases only
                            if (opWord == sfs_pkg::OP_READ_TABLE &&
                                !resetBusy) begin
                                next_state = sfs_pkg::ST_ADDR;
                            end else begin
                                next_state = sfs_pkg::ST_IGNORE;
                            end
                        end
                    end
                    sfs_pkg::ST_ADDR: begin
                        // Only the low byte indexes the 256-byte table
                        next_addr = {addr[6:0], pinsSync.mosi};
                        next_cnt = cnt + 5'h01;
                        if (cnt == sfs_pkg::ADDR_LAST) begin
                            next_state = sfs_pkg::ST_DUMMY;
                            next_cnt = 5'h00;
                        end
                    end
                    sfs_pkg::ST_DUMMY: begin
                        // Wait states right after the address
                        next_cnt = cnt + 5'h01;
                        if (cnt == sfs_pkg::DUMMY_LAST) begin
                            next_state = sfs_pkg::ST_DATA;
                            next_cnt = 5'h00;
                            next_bitOut = 3'h0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (fallE && state == sfs_pkg::ST_DATA) begin
                // Each falling edge starts a new output cycle
                next_misoOe = 1'b1;
                next_bitOut = bitOut + 3'h1;
                if (bitOut == 3'h0) begin
                    next_miso = romData[7];
                    next_outShift = {romData[6:0], 1'b0};
                    next_addr = addr + 8'h01;
                end else begin
                    next_miso = outShift[7];
                    next_outShift = {outShift[6:0], 1'b0};
                end
            end
        end
    end

    // Keeps the deselect branch readable
    function automatic sfs_pkg::sfs_state_t sfs_sets_cmd();
        return sfs_pkg::ST_CMD;
    endfunction

    // State registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= sfs_pkg::ST_CMD;
            cnt <= 5'h00;
            shiftIn <= 8'h00;
            addr <= 8'h00;
            outShift <= 8'h00;
            bitOut <= 3'h0;
            lastOp <= 8'h00;
            opDone <= 1'b0;
            armed <= 1'b0;
            busyCnt <= 12'h000;
            resetBusy <= 1'b0;
            miso <= 1'b0;
            misoOe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shiftIn <= next_shiftIn;
            addr <= next_addr;
            outShift <= next_outShift;
            bitOut <= next_bitOut;
            lastOp <= next_lastOp;
            opDone <= next_opDone;
            armed <= next_armed;
            busyCnt <= next_busyCnt;
            resetBusy <= next_resetBusy;
            miso <= next_miso;
            misoOe <= next_misoOe;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Deselects that end a completed one-byte command
    sequence s_reset_enable_done;
        csRise && opDone && lastOp == sfs_pkg::OP_RESET_ENABLE && !resetBusy;
    endsequence

    sequence s_reset_done;
        csRise && opDone && lastOp == sfs_pkg::OP_RESET;
    endsequence

    a_miso_on_fall:
    assert property ($changed(miso) |-> $past(fallE) &&
                     $past(state) == sfs_pkg::ST_DATA)
        else $error("output bit moved off a falling edge");
    a_sample_on_rise:
    assert property ($changed(shiftIn) |-> $past(riseE) &&
                     $past(state) == sfs_pkg::ST_CMD)
        else $error("opcode bit taken off a rising edge");
    a_cs_restart:
    assert property (pinsSync.csN |=> state == sfs_pkg::ST_CMD &&
                     cnt == 5'h00 && !misoOe)
        else $error("deselect did not restart the frame");
    a_dummy_length:
    assert property (state == sfs_pkg::ST_DUMMY && riseE && cnt == 5'h07 &&
                     !pinsSync.csN |=> state == sfs_pkg::ST_DATA)
        else $error("data phase not after eight dummy cycles");
    a_addr_to_dummy:
    assert property (state == sfs_pkg::ST_ADDR ##1 state == sfs_pkg::ST_DUMMY
                     |-> $past(cnt) == 5'h17 && cnt == 5'h00)
        else $error("address phase not 24 bits");
    a_read_needs_idle:
    assert property (state != sfs_pkg::ST_ADDR ##1 state == sfs_pkg::ST_ADDR
                     |-> !$past(resetBusy) &&
                     lastOp == sfs_pkg::OP_READ_TABLE)
        else $error("table read began while busy or with wrong opcode");
    a_enable_arms:
    assert property (s_reset_enable_done |=> armed)
        else $error("reset enable did not arm");
    a_reset_pair:
    assert property (armed ##0 s_reset_done |=> resetBusy &&
                     busyCnt == sfs_pkg::RESET_COUNT_LOAD)
        else $error("reset pair did not start the reset period");
    a_reset_lone:
    assert property ((!armed && !resetBusy) ##0 s_reset_done |=>
                     !resetBusy)
        else $error("lone reset started the reset period");
    a_busy_refuses:
    assert property (resetBusy && riseE && state == sfs_pkg::ST_CMD &&
                     cnt == sfs_pkg::OPCODE_LAST && !pinsSync.csN |=>
                     state == sfs_pkg::ST_IGNORE)
        else $error("command taken during the reset period");
    a_oe_in_data:
    assert property (misoOe && !pinsSync.csN |-> state == sfs_pkg::ST_DATA)
        else $error("output driven outside the data phase");
    a_ignore_quiet:
    assert property (state == sfs_pkg::ST_IGNORE |-> !misoOe)
        else $error("dropped command drove the output");
    a_busy_end:
    assert property (resetBusy && busyCnt == 12'h000 |=> !resetBusy)
        else $error("reset period did not end on time");
    a_stream_next:
    assert property (fallE && state == sfs_pkg::ST_DATA && bitOut == 3'h0 &&
                     !pinsSync.csN |=> addr == 8'($past(addr) + 8'h01) &&
                     miso == $past(romData[7]))
        else $error("byte stream did not advance");

endmodule

// ### sim/sfs_master_model.sv
// Serial bus master model that drives frames and collects read bytes
`timescale 1ns/10ps
module sfs_master_model (
    // Serial link pins
    output logic csN,
    output logic sclk,
    output logic mosi,
    input wire logic miso,
    input wire logic misoOe
);
    logic [7:0] gotQ[$];
    logic mode3;
    logic oeSeen;

    // Deselected, clock parked low for mode 0
    initial begin
        mode3 = 1'b0;
        oeSeen = 1'b0;
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Note any drive by the slave within a frame
    always @(posedge misoOe) oeSeen = 1'b1;

    // Park the clock at the idle level of the chosen mode
    task automatic set_mode(input logic m3);
        mode3 = m3;
        sclk = m3;
        #40;
    endtask

    // Opcode, address, eight dummy cycles, then nRd bytes (opcode alone for 66h, 99h); low phase 20 ns
    // and high 12 ns so miso is taken well after the slave's answer
    task automatic frame(input logic [7:0] op, input logic [23:0] addr,
        input int nRd);
        logic [63:0] sh;
        logic [7:0] rd;
        int nBits;
        oeSeen = 1'b0;
        rd = 8'h00;
        sh = {op, addr, 8'h00, 24'h00_0000};
        nBits = (op == 8'h66 || op == 8'h99) ? 8 : 40 + 8 * nRd;
        csN = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            #8 sclk = 1'b0;
            mosi = (i < 40) ? sh[63 - i] : ~mosi;
            #19 rd = {rd[6:0], miso};
            if (i >= 40 && (i - 40) % 8 == 7 && misoOe === 1'b1) begin
                gotQ.push_back(rd);
            end
            #1 sclk = 1'b1;
            #4;
        end
        #8 sclk = mode3;
        #8 csN = 1'b1;
        mosi = ~mosi; // Released line must not keep its last value
        #40;
    endtask
endmodule

// ### sim/sfs_table_slave_tb.sv
// Self-checking bench of the table slave driven by the master model
`timescale 1ns/10ps
module sfs_table_slave_tb;
    logic clock;
    logic rst;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;
    logic misoOe;
    logic resetBusy;
    logic [7:0] expQ[$];
    logic [31:0] lfsr;
    logic [7:0] op;
    int n_fail;
    int n_checks;
    int len;

    // Core clock, 4 ns period
    always #2 clock = ~clock;

    sfs_table_slave uut (.clock(clock), .rst(rst), .csN(csN), .sclk(sclk),
        .mosi(mosi), .miso(miso), .misoOe(misoOe), .resetBusy(resetBusy));
    sfs_master_model mst (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
        .misoOe(misoOe));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Expected byte, written out independently of the design's constants
    function automatic logic [7:0] tbl(input logic [7:0] a);
        logic [31:0] w;
        case (a[7:2])
            6'h14: w = 32'hFF00_D810;
            6'h18: w = 32'h2700_3600;
            6'h19: w = 32'h6477_F99F;
            6'h1A: w = 32'hFFFF_F800;
            default: w = 32'hFFFF_FFFF;
        endcase
        return w[a[1:0] * 8 +: 8];
    endfunction

    // Note the bytes a read should return, then run it
    task automatic read(input logic [23:0] addr, input int n);
        for (int k = 0; k < n; k++) begin
            expQ.push_back(tbl(8'(addr + 24'(k))));
        end
        mst.frame(8'h5A, addr, n);
        chk(32'(expQ.size()), 32'h0000_0000);
    endtask

    // Wait bounded for busy to rise, then count its length in cycles
    task automatic busy_len(output int n);
        int w;
        n = 0;
        w = 0;
        while (resetBusy !== 1'b1 && w < 200) begin
            @(negedge clock);
            w++;
        end
        while (resetBusy === 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (n == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    // Each collected byte is compared with the oldest note
    always @(negedge clock) begin
        if (mst.gotQ.size() > 0) begin
            chk(mst.gotQ.pop_front(),
                expQ.size() > 0 ? expQ.pop_front() : 32'hxxxx_xxxx);
        end
    end

    // Hang guard
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        n_fail = 0;
        n_checks = 0;
        lfsr = 32'h0000_b427;
        repeat (20) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        repeat (3) @(negedge clock);
        // Whole upper table plus blank neighbours, mode 0
        read(24'h00_004E, 36);
        // Mode 3, wrap at the top of the index, random places
        mst.set_mode(1'b1);
        read(24'hFF_FFFE, 4);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            read(lfsr[23:0], 3);
        end
        // Unknown opcodes are dropped without any drive
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            op = lfsr[7:0];
            if (op == 8'h5A || op == 8'h66 || op == 8'h99) begin
                op = 8'h00;
            end
            mst.frame(op, lfsr[31:8], 2);
            chk(32'(mst.oeSeen), 32'h0000_0000);
        end
        // Reset without its enable does nothing
        mst.set_mode(1'b0);
        fork
            busy_len(len);
            mst.frame(8'h99, 24'h00_0000, 0);
        join
        chk(32'(len), 32'h0000_0000);
        // Another command between enable and reset disarms it
        mst.frame(8'h66, 24'h00_0000, 0);
        read(24'h00_0060, 1);
        fork
            busy_len(len);
            mst.frame(8'h99, 24'h00_0000, 0);
        join
        chk(32'(len), 32'h0000_0000);
        // Proper pair: 10 us busy, reads refused meanwhile
        mst.frame(8'h66, 24'h00_0000, 0);
        fork
            busy_len(len);
            begin
                mst.frame(8'h99, 24'h00_0000, 0);
                mst.frame(8'h5A, 24'h00_0050, 2);
                chk(32'(mst.oeSeen), 32'h0000_0000);
            end
        join
        chk(32'(len), 32'h0000_09C4);
        // Service resumes afterwards, mode 3
        mst.set_mode(1'b1);
        read(24'h00_0066, 2);
        repeat (10) @(negedge clock);
        tally_and_finish();
    end
endmodule
